// file: dsd_analog_model.sv
// Model of the comparator columns and the digital clock blocks
module dsd_analog_model (
    input wire logic clk,
    output logic [3:0] columnComparators,
    output logic basicBlockClock,
    output logic commBlockClock,
    output logic altLatchClock
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock lines stand low outside bursts
    initial begin
        columnComparators = 4'h0;
        basicBlockClock = 1'b0;
        commBlockClock = 1'b0;
        altLatchClock = 1'b0;
    end
    // Comparator levels change right after an edge
    task automatic setColumns(input logic [3:0] bits);
        @(posedge clk);
        columnComparators <= bits;
    endtask
    // Source 0 basic block, 1 comm block, 2 alternate latch clock
    task automatic setLevel(input int src, input logic lvl);
        @(posedge clk);
        case (src)
            0: basicBlockClock <= lvl;
            1: commBlockClock <= lvl;
            default: altLatchClock <= lvl;
        endcase
    endtask
    // Levels last three cycles so the input syncs never drop an edge
    task automatic pulse(input int src, input int n);
        for (int i = 0; i < n; i++) begin
            setLevel(src, 1'b1);
            repeat (2) @(posedge clk);
            setLevel(src, 1'b0);
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// file: dsd_decimator.sv
// Decimator front end: comparator select, latch, accumulator, APB registers
// Function
// RULE1: Hardware accumulates the fast one-bit comparator stream.
// RULE2: Firmware does the remaining low-rate filtering of the sum.
// RULE3: Hardware and firmware together form a divide-by-n decimator.
// RULE4: Source field bits 2:1 pick comparator column 0 to 3.
// RULE5: Latch clock select bit 0 picks the latch clock, 0 = block 02.
// RULE6: Gate clock select bit 3 picks block 02 (0) or block 06 (1).
// RULE7: Gate enable bits 7:4 each gate their column's comparator.
// RULE8: Reading the high register returns the upper result byte.
// RULE9: Any write to the high register clears the whole 16-bit sum; the code clears it only when paddr[1:0] is 0.
// RULE10: The low register is read-only and returns the lower byte.
// RULE11: Each selected latch clock edge adds the bit, wrapping, reset 0.
//
// The APB register port was chosen for this implementation.
module dsd_decimator (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] columnComparators,
    input wire logic basicBlockClock,
    input wire logic commBlockClock,
    input wire logic altLatchClock,
    output logic [3:0] columnGateActive
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] control;
        logic [15:0] accum;
        logic [31:0] rdata;
        logic [3:0] comp1, comp2, comp3;
        logic [2:0] basicSync, commSync, altSync;
        logic basicSt, commSt, altSt;
        logic [3:0] compSt;
        logic latchPrev;
        logic [3:0] gate;
        dsd_pkg::dsd_bus_t bus;
    } dsd_state_t;

    dsd_state_t s_q, s_d;

    logic [1:0] sourceSel;
    logic latchSel, gateSel, latchClk, latchEdge, sampleBit, gateClk;
    logic fifoInReady, fifoOutValid, fifoOutData, accept, clearHit;
    logic setupRead, setupWrite;
    logic [9:0] wordAddr;

    // Word indices as they appear on paddr[11:2], not byte addresses
    localparam logic [9:0] W_HIGH = {2'b00, dsd_pkg::IDX_DATA_HIGH_CLEAR};
    localparam logic [9:0] W_LOW = {2'b00, dsd_pkg::IDX_DATA_LOW};
    localparam logic [9:0] W_CTL = {2'b00, dsd_pkg::IDX_CONTROL};

    // Agreement filter: a pin change counts once stages two and three agree
    function automatic logic agree(input logic stable, input logic a,
                                   input logic b);
        agree = (a == b) ? a : stable;
    endfunction

    // ****************************************************************
    // Field decode
    // ****************************************************************
    assign sourceSel = s_q.control[dsd_pkg::CTL_SOURCE_LSB +: 2]; // RULE4
    assign latchSel = s_q.control[dsd_pkg::CTL_LATCH_CLK_BIT]; // RULE5
    assign gateSel = s_q.control[dsd_pkg::CTL_GATE_CLK_BIT]; // RULE6
    // Latch clock: 0 = basic block, 1 = alternate source
    assign latchClk = latchSel ? s_q.altSt : s_q.basicSt; // RULE5
    assign gateClk = gateSel ? s_q.commSt : s_q.basicSt; // RULE6
    assign latchEdge = latchClk && !s_q.latchPrev; // RULE11
    assign sampleBit = s_q.compSt[sourceSel]; // RULE4
    assign wordAddr = paddr[11:2];
    assign setupRead = psel && !penable && !pwrite;
    assign setupWrite = psel && !penable && pwrite;
    assign clearHit = setupWrite &&
        (wordAddr == W_HIGH) &&
        (paddr[1:0] == 2'b00);
    assign accept = fifoOutValid;

    // Samples buffered so the accumulator may lag a burst of edges
    dsd_fifo #(
        .WIDTH(dsd_pkg::FIFO_WIDTH),
        .DEPTH(dsd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .inValid(latchEdge),
        .inReady(fifoInReady),
        .inData(sampleBit),
        .outValid(fifoOutValid),
        .outReady(!clearHit),
        .outData(fifoOutData)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        // Three-stage synchronisers; stage one feeds only stage two
        s_d.comp1 = columnComparators;
        s_d.comp2 = s_q.comp1;
        s_d.comp3 = s_q.comp2;
        s_d.basicSync = {s_q.basicSync[1:0], basicBlockClock};
        s_d.commSync = {s_q.commSync[1:0], commBlockClock};
        s_d.altSync = {s_q.altSync[1:0], altLatchClock};
        for (int i = 0; i < 4; i++) begin
            s_d.compSt[i] = agree(s_q.compSt[i], s_q.comp2[i], s_q.comp3[i]);
        end
        s_d.basicSt = agree(s_q.basicSt, s_q.basicSync[1], s_q.basicSync[2]);
        s_d.commSt = agree(s_q.commSt, s_q.commSync[1], s_q.commSync[2]);
        s_d.altSt = agree(s_q.altSt, s_q.altSync[1], s_q.altSync[2]);
        // Latch edge is only taken while the FIFO has room; a full FIFO
        // leaves latchPrev low so the edge is retried next cycle
        s_d.latchPrev = latchClk && (s_q.latchPrev || fifoInReady);
        // Per-column gate follows the chosen gate clock when enabled
        for (int i = 0; i < 4; i++) begin
            s_d.gate[i] = s_q.control[dsd_pkg::CTL_GATE_EN_LSB + i]
                && gateClk; // RULE7
        end
        // Accumulate drained samples, wrapping; clear has priority
        if (clearHit) begin
            s_d.accum = dsd_pkg::ACCUM_RESET; // RULE9
        end else if (accept) begin
            s_d.accum = s_q.accum + 16'(fifoOutData); // RULE1 RULE3 RULE11
        end
        // APB: answer one cycle after setup, always ready in access
        case (s_q.bus)
            dsd_pkg::BUS_IDLE: begin
                if (psel && !penable) begin
                    s_d.bus = dsd_pkg::BUS_DONE;
                end
            end
            dsd_pkg::BUS_DONE: begin
                s_d.bus = dsd_pkg::BUS_IDLE;
            end
            default: begin
                s_d.bus = dsd_pkg::BUS_IDLE;
            end
        endcase
        if (setupWrite && wordAddr == W_CTL) begin
            s_d.control = pwdata[7:0];
        end
        if (setupRead) begin
            case (wordAddr)
                W_HIGH:
                    s_d.rdata = {24'h000000, s_q.accum[15:8]}; // RULE8
                W_LOW:
                    s_d.rdata = {24'h000000, s_q.accum[7:0]}; // RULE10
                W_CTL:
                    s_d.rdata = {24'h000000, s_q.control};
                default:
                    s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Register stage
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0; // RULE11
            s_q.control <= dsd_pkg::CONTROL_RESET;
            s_q.bus <= dsd_pkg::BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; writes to the low register are silently ignored
    assign prdata = s_q.rdata;
    assign pready = (s_q.bus == dsd_pkg::BUS_DONE);
    assign pslverr = 1'b0;
    assign columnGateActive = s_q.gate;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_clear;
        @(posedge clk) disable iff (reset)
        clearHit |=> (s_q.accum == 16'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("clear missed"); // RULE9

    property p_accum;
        @(posedge clk) disable iff (reset)
        (accept && !clearHit) |=>
            (s_q.accum == $past(s_q.accum) + 16'($past(fifoOutData)));
    endproperty
    a_accum: assert property (p_accum) else $error("bad sum"); // RULE11

    property p_hold;
        @(posedge clk) disable iff (reset)
        (!accept && !clearHit) |=> $stable(s_q.accum);
    endproperty
    a_hold: assert property (p_hold) else $error("sum moved"); // RULE1

    property p_high;
        @(posedge clk) disable iff (reset)
        (setupRead && wordAddr == W_HIGH)
            |=> pready && prdata == {24'h000000, $past(s_q.accum[15:8])};
    endproperty
    a_high: assert property (p_high) else $error("high byte"); // RULE8

    property p_low;
        @(posedge clk) disable iff (reset)
        (setupRead && wordAddr == W_LOW)
            |=> pready && prdata == {24'h000000, $past(s_q.accum[7:0])};
    endproperty
    a_low: assert property (p_low) else $error("low byte"); // RULE10

    property p_source;
        @(posedge clk) disable iff (reset)
        latchEdge && fifoInReady && !fifoOutValid |=>
            fifoOutData == $past(s_q.compSt[sourceSel]);
    endproperty
    a_source: assert property (p_source) else $error("source"); // RULE4

    property p_gate;
        @(posedge clk) disable iff (reset)
        ##1 columnGateActive == ($past(s_q.control[7:4]) &
            {4{$past(gateSel ? s_q.commSt : s_q.basicSt)}});
    endproperty
    a_gate: assert property (p_gate) else $error("gate"); // RULE6 RULE7

    property p_latch;
        @(posedge clk) disable iff (reset)
        (!latchSel && s_q.basicSt && !s_q.latchPrev && fifoInReady)
            |-> latchEdge;
    endproperty
    a_latch: assert property (p_latch) else $error("latch sel"); // RULE5

    property p_ctl_write;
        @(posedge clk) disable iff (reset)
        (setupWrite && wordAddr == W_CTL)
            |=> (s_q.control == $past(pwdata[7:0]));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("ctl"); // RULE4

    property p_ctl_keep;
        @(posedge clk) disable iff (reset)
        !(setupWrite && wordAddr == W_CTL)
            |=> $stable(s_q.control);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("ctl"); // RULE10

    property p_edge_once;
        @(posedge clk) disable iff (reset)
        (latchEdge && fifoInReady)
            |=> !latchEdge;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge"); // RULE11

    property p_alt_only;
        @(posedge clk) disable iff (reset)
        (latchSel && !s_q.altSt)
            |-> !latchEdge;
    endproperty
    a_alt_only: assert property (p_alt_only) else $error("alt"); // RULE5

    property p_wrap;
        @(posedge clk) disable iff (reset)
        (accept && !clearHit && s_q.accum == 16'hFFFF && fifoOutData)
            |=> (s_q.accum == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap"); // RULE11

    property p_gate_off;
        @(posedge clk) disable iff (reset)
        (s_q.control[dsd_pkg::CTL_GATE_EN_LSB +: 4] == 4'h0)
            |=> (columnGateActive == 4'h0);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate off"); // RULE7

    property p_comm_gate;
        @(posedge clk) disable iff (reset)
        (gateSel && !s_q.commSt)
            |=> (columnGateActive == 4'h0);
    endproperty
    a_comm_gate: assert property (p_comm_gate) else $error("comm"); // RULE6

    property p_ready_once;
        @(posedge clk) disable iff (reset)
        pready
            |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("rdy"); // RULE8

    c_clear: cover property (@(posedge clk) disable iff (reset) clearHit);
    c_full: cover property (@(posedge clk) disable iff (reset) !fifoInReady);
    c_wrap: cover property (@(posedge clk) disable iff (reset)
        accept && s_q.accum == 16'hFFFF && fifoOutData);
    c_alt: cover property (@(posedge clk) disable iff (reset)
        latchSel && latchEdge);
    c_gate: cover property (@(posedge clk) disable iff (reset)
        columnGateActive != 4'h0);
endmodule

// file: dsd_fifo.sv
// Sample FIFO between the latch stage and the accumulator
module dsd_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } dsd_fifo_state_t;

    logic [WIDTH-1:0] mem [DEPTH];
    dsd_fifo_state_t s_q, s_d;
    logic push, pop;

    // Honest full and empty from the word count
    assign inReady = (s_q.count != (AW+1)'(DEPTH));
    assign outValid = (s_q.count != '0);
    assign outData = mem[s_q.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wrPtr = s_q.wrPtr + AW'(1);
        end
        if (pop) begin
            s_d.rdPtr = s_q.rdPtr + AW'(1);
        end
        s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage array is not reset; only pointers and count are
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (push) begin
            mem[s_q.wrPtr] <= inData;
        end
    end
endmodule

// file: dsd_pkg.sv
// Package: register map, field layout and reset values of the decimator
package dsd_pkg;

    // ****************************************************************
    // Register indices (printed offsets are not word multiples)
    // ****************************************************************
    localparam logic [7:0] IDX_DATA_HIGH_CLEAR = 8'hE4;
    localparam logic [7:0] IDX_DATA_LOW = 8'hE5;
    localparam logic [7:0] IDX_CONTROL = 8'hE6;
    localparam logic [9:0] ADDR_DATA_HIGH_CLEAR = {IDX_DATA_HIGH_CLEAR, 2'b00};
    localparam logic [9:0] ADDR_DATA_LOW = {IDX_DATA_LOW, 2'b00};
    localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTL_LATCH_CLK_BIT = 0;
    localparam int CTL_SOURCE_LSB = 1;
    localparam int CTL_GATE_CLK_BIT = 3;
    localparam int CTL_GATE_EN_LSB = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] ACCUM_RESET = 16'h0000;

    // ****************************************************************
    // Sample buffer shape
    // ****************************************************************
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 1;
    localparam logic [3:0] FIFO_COUNT_RESET = 4'h0;

    // Bus answer state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } dsd_bus_t;

endpackage

// file: testbench.sv
// Self-checking bench for the decimator front end
`define CHECK(g, e) begin cmpCount++; if ((g) !== (e)) begin errCount++; \
    $display("[FAIL] t=%0t got %0h want %0h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] HI = {2'b00, dsd_pkg::ADDR_DATA_HIGH_CLEAR};
    localparam logic [11:0] LO = {2'b00, dsd_pkg::ADDR_DATA_LOW};
    localparam logic [11:0] CTL = {2'b00, dsd_pkg::ADDR_CONTROL};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slvErr;
    logic [3:0] cols;
    logic bClk;
    logic cClk;
    logic aClk;
    logic [3:0] gates;
    logic [31:0] q;
    int errCount = 0;
    int cmpCount = 0;
    dsd_decimator u_dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .columnComparators(cols),
        .basicBlockClock(bClk), .commBlockClock(cClk), .altLatchClock(aClk),
        .columnGateActive(gates));
    dsd_analog_model u_model (.clk(clk), .columnComparators(cols),
        .basicBlockClock(bClk), .commBlockClock(cClk), .altLatchClock(aClk));
    // 50 MHz clock
    always #10 clk = ~clk;
    task automatic finishTest();
        $display("compares %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One APB transfer; a missing pready ends the run
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errCount++;
            finishTest();
        end
        r = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Firmware side: poll the low byte until it reads as expected, then read the high byte
    task automatic expectSum(input logic [15:0] e);
        logic [31:0] lo;
        int n;
        n = 0;
        do begin
            apb(1'b0, LO, 32'h0, lo);
            n++;
        end while (lo !== {24'h0, e[7:0]} && n < 30);
        apb(1'b0, HI, 32'h0, q);
        `CHECK(lo, {24'h0, e[7:0]})
        `CHECK(q, {24'h0, e[15:8]})
    endtask
    // Gate outputs pass the input syncs, so allow a few cycles
    task automatic waitGate(input logic [3:0] e);
        for (int i = 0; i < 12 && gates !== e; i++) @(posedge clk);
        `CHECK(gates, e)
    endtask
    task automatic testRegs();
        apb(1'b0, CTL, 32'h0, q);
        `CHECK(q, 32'h0)
        expectSum(16'h0000);
        apb(1'b1, CTL, 32'hA5, q);
        apb(1'b1, LO, 32'hFF, q);
        apb(1'b1, 12'h3FC, 32'hFF, q);
        apb(1'b0, CTL, 32'h0, q);
        `CHECK(q, 32'hA5)
        apb(1'b0, 12'h3FC, 32'h0, q);
        `CHECK(q, 32'h0)
        expectSum(16'h0000);
        $display("registers done");
    endtask
    // Each source code counts only its own column
    task automatic testSources();
        u_model.setColumns(4'h5);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, CTL, 32'(s << 1), q);
            apb(1'b1, HI, 32'h5A, q);
            u_model.pulse(0, 3);
            expectSum((s % 2 == 0) ? 16'h0003 : 16'h0000);
        end
        apb(1'b1, HI, 32'h0, q);
        expectSum(16'h0000);
        $display("sources done");
    endtask
    task automatic testLatchSelect();
        u_model.setColumns(4'h1);
        apb(1'b1, CTL, 32'h01, q);
        u_model.pulse(0, 2);
        u_model.pulse(2, 4);
        expectSum(16'h0004);
        apb(1'b1, CTL, 32'h00, q);
        u_model.pulse(2, 2);
        u_model.pulse(0, 1);
        expectSum(16'h0005);
        // A write to the read-only low byte must leave the sum alone
        apb(1'b1, LO, 32'hFF, q);
        `CHECK(slvErr, 1'b0)
        expectSum(16'h0005);
        $display("latch select done");
    endtask
    // Low byte carries into the high byte
    task automatic testCarry();
        apb(1'b1, HI, 32'h0, q);
        u_model.pulse(0, 257);
        expectSum(16'h0101);
        $display("carry done");
    endtask
    task automatic testGate();
        apb(1'b1, CTL, 32'hA0, q);
        u_model.setLevel(0, 1'b1);
        waitGate(4'hA);
        u_model.setLevel(0, 1'b0);
        u_model.setLevel(1, 1'b1);
        waitGate(4'h0);
        apb(1'b1, CTL, 32'hA8, q);
        waitGate(4'hA);
        u_model.setLevel(1, 1'b0);
        waitGate(4'h0);
        $display("gating done");
    endtask
    // Reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        testRegs();
        testSources();
        testLatchSelect();
        testCarry();
        testGate();
        finishTest();
    end
endmodule
